/* File: rtl/backlight_pkg.sv */
// Constants, register map and fade timing for the backlight level and current register bank
//
// Contract
// - Upper fade nibble: codes 1..10 give 0.3 s steps, 11..15 give 0.5 s up to 5.5 s.
// - Lower fade nibble uses the same code-to-time mapping as the upper nibble.
// - A fade code of zero disables the timer; the transition is immediate.
// - Three separate 7-bit peak codes, one per level, driven when fully on.
// - Three separate 7-bit dimmed codes, one per level, driven while dimmed.
// - Daylight picks level 1 codes, office level 2, dark level 3.
// - Read-only register shows the code applied now, fades included; writes ignored.
// - Level selector encodes daylight 00, office 01, dark 10.
// - Fade curve select: 00 linear, 01 square, 10 and 11 two different cubics.
// - With auto level enabled, comparator-driven level replaces host-written level.
`default_nettype none

package backlight_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_FADE_DURATIONS = 8'h04;
  localparam logic [7:0] ADDR_LEVEL1_PEAK = 8'h05;
  localparam logic [7:0] ADDR_LEVEL1_DIMMED = 8'h06;
  localparam logic [7:0] ADDR_LEVEL2_PEAK = 8'h07;
  localparam logic [7:0] ADDR_LEVEL2_DIMMED = 8'h08;
  localparam logic [7:0] ADDR_LEVEL3_PEAK = 8'h09;
  localparam logic [7:0] ADDR_LEVEL3_DIMMED = 8'h0A;
  localparam logic [7:0] ADDR_APPLIED_CODE = 8'h0B;

  localparam int FADE_OUT_LSB = 4;
  localparam int FADE_IN_LSB = 0;

  localparam logic [7:0] RST_FADE_DURATIONS = 8'h00;
  localparam logic [6:0] RST_CURRENT_CODE = 7'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // Level and curve encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    LEVEL_DAYLIGHT = 2'b00,
    LEVEL_OFFICE = 2'b01,
    LEVEL_DARK = 2'b10,
    LEVEL_SPARE = 2'b11
  } level_type;

  typedef enum logic [1:0] {
    CURVE_LINEAR = 2'b00,
    CURVE_SQUARE = 2'b01,
    CURVE_CUBIC1 = 2'b10,
    CURVE_CUBIC2 = 2'b11
  } curve_type;

  // ****************************************************************
  // Fade timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  // Durations are counted in tenths of a second
  localparam int FADE_UNIT_MS = 100;
  localparam int FADE_PHASES = 128;
  localparam logic [7:0] PHASE_LAST = 8'h80;
  localparam int PHASE_CYC_PER_UNIT = (CLK_HZ / 1000) * FADE_UNIT_MS / FADE_PHASES;

  localparam logic [3:0] FADE_KNEE_CODE = 4'hA;
  localparam logic [5:0] FADE_FINE_STEP = 6'h03;
  localparam logic [5:0] FADE_COARSE_STEP = 6'h05;
  localparam logic [5:0] FADE_KNEE_UNITS = 6'h1E;

  // Fade code to duration in tenths of a second
  function automatic logic [5:0] fade_units(input logic [3:0] code);
    logic [5:0] c;
    c = {2'b00, code};
    if (code <= FADE_KNEE_CODE) begin
      fade_units = 6'((c * FADE_FINE_STEP));
    end else begin
      fade_units = 6'(FADE_KNEE_UNITS + (c - {2'b00, FADE_KNEE_CODE}) * FADE_COARSE_STEP);
    end
  endfunction : fade_units

endpackage : backlight_pkg

`default_nettype wire

/* File: rtl/fade_shaper.sv */
// Combinational fade curve: blends start and target codes by fade phase
`default_nettype none

module fade_shaper
  import backlight_pkg::*;
(
  input wire logic [6:0] i_start,      // Code at fade start
  input wire logic [6:0] i_target,     // Code at fade end
  input wire logic [7:0] i_phase,      // Progress 0..128
  input wire logic [1:0] i_curve,      // Curve select
  output logic [6:0] o_code            // Blended code
);

  logic [7:0] inv;
  logic [31:0] p3;
  logic [31:0] q3;
  logic [31:0] shape;
  logic [6:0] delta;
  logic [31:0] offset;

  always_comb begin
    inv = PHASE_LAST - i_phase;
    p3 = 32'(i_phase) * 32'(i_phase) * 32'(i_phase);
    q3 = 32'(inv) * 32'(inv) * 32'(inv);
    unique case (curve_type'(i_curve))
      CURVE_LINEAR: shape = 32'(i_phase);
      CURVE_SQUARE: shape = (32'(i_phase) * 32'(i_phase)) >> 7;
      CURVE_CUBIC1: shape = p3 >> 14;
      CURVE_CUBIC2: shape = 32'(PHASE_LAST) - (q3 >> 14);
    endcase
    delta = (i_target >= i_start) ? (i_target - i_start) : (i_start - i_target);
    offset = (32'(delta) * shape) >> 7;
    if (i_target >= i_start) begin
      o_code = i_start + offset[6:0];
    end else begin
      o_code = i_start - offset[6:0];
    end
  end

endmodule : fade_shaper

`default_nettype wire

/* File: rtl/backlight_regs.sv */
// Backlight fade and current register bank with level selection and fade engine
`default_nettype none

module backlight_regs
  import backlight_pkg::*;
#(
  parameter int PHASE_CYC = PHASE_CYC_PER_UNIT  // Cycles per phase step per tenth second
) (
  input wire logic i_ref_clk,                 // 20 MHz clock
  input wire logic i_rst_n,                   // Async reset, active low
  input wire logic i_reg_wr,                  // Register write strobe
  input wire logic [7:0] i_reg_addr,          // Register address
  input wire logic [7:0] i_reg_wdata,         // Register write data
  output logic [7:0] o_reg_rdata,             // Read data, one cycle after address
  input wire logic i_backlight_on,            // Backlight enable
  input wire logic i_dimmed,                  // Dim timer has expired
  input wire logic [1:0] i_ambient_level_sel, // Host-written level
  input wire logic i_auto_level_enable,       // Comparators own the level
  input wire logic [1:0] i_auto_level,        // Level from comparator state machine
  input wire logic [1:0] i_fade_curve_sel,    // Fade transfer law
  output logic [6:0] o_sink_code,             // Code applied to the sink
  output logic [1:0] o_active_level,          // Level in force
  output logic o_fading                       // Fade in progress
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] fade_q;
  logic [7:0] fade_d;
  logic [6:0] peak_q [3];
  logic [6:0] peak_d [3];
  logic [6:0] dim_q [3];
  logic [6:0] dim_d [3];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic [3:0] fade_out_code;
  logic [3:0] fade_in_code;

  assign fade_out_code = fade_q[FADE_OUT_LSB +: 4];
  assign fade_in_code = fade_q[FADE_IN_LSB +: 4];

  logic [6:0] applied_q;

  always_comb begin
    fade_d = fade_q;
    for (int i = 0; i < 3; i++) begin
      peak_d[i] = peak_q[i];
      dim_d[i] = dim_q[i];
    end
    if (i_reg_wr) begin
      // bit 7 of current codes dropped on write; applied code not writable
      unique case (i_reg_addr)
        ADDR_FADE_DURATIONS: fade_d = i_reg_wdata;
        ADDR_LEVEL1_PEAK: peak_d[0] = i_reg_wdata[6:0];
        ADDR_LEVEL2_PEAK: peak_d[1] = i_reg_wdata[6:0];
        ADDR_LEVEL3_PEAK: peak_d[2] = i_reg_wdata[6:0];
        ADDR_LEVEL1_DIMMED: dim_d[0] = i_reg_wdata[6:0];
        ADDR_LEVEL2_DIMMED: dim_d[1] = i_reg_wdata[6:0];
        ADDR_LEVEL3_DIMMED: dim_d[2] = i_reg_wdata[6:0];
        default: ;
      endcase
    end
    unique case (i_reg_addr)
      ADDR_FADE_DURATIONS: rdata_d = fade_q;
      ADDR_LEVEL1_PEAK: rdata_d = {1'b0, peak_q[0]};
      ADDR_LEVEL2_PEAK: rdata_d = {1'b0, peak_q[1]};
      ADDR_LEVEL3_PEAK: rdata_d = {1'b0, peak_q[2]};
      ADDR_LEVEL1_DIMMED: rdata_d = {1'b0, dim_q[0]};
      ADDR_LEVEL2_DIMMED: rdata_d = {1'b0, dim_q[1]};
      ADDR_LEVEL3_DIMMED: rdata_d = {1'b0, dim_q[2]};
      ADDR_APPLIED_CODE: rdata_d = {1'b0, applied_q};
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fade_q <= RST_FADE_DURATIONS;
      rdata_q <= UNMAPPED_READ;
      for (int i = 0; i < 3; i++) begin
        peak_q[i] <= RST_CURRENT_CODE;
        dim_q[i] <= RST_CURRENT_CODE;
      end
    end else begin
      fade_q <= fade_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < 3; i++) begin
        peak_q[i] <= peak_d[i];
        dim_q[i] <= dim_d[i];
      end
    end
  end

  // ****************************************************************
  // Level selection and target code
  // ****************************************************************
  logic [1:0] level_q;
  logic [1:0] level_d;
  logic [1:0] level_idx;
  logic [6:0] target_w;

  always_comb begin
    level_d = i_auto_level_enable ? i_auto_level : i_ambient_level_sel;
    // level to code pair; the unused code falls back to dark
    unique case (level_type'(level_d))
      LEVEL_DAYLIGHT: level_idx = 2'h0;
      LEVEL_OFFICE: level_idx = 2'h1;
      LEVEL_DARK: level_idx = 2'h2;
      LEVEL_SPARE: level_idx = 2'h2;
    endcase
    // peak when fully on, dimmed code when dimmed
    if (!i_backlight_on) begin
      target_w = 7'h00;
    end else if (i_dimmed) begin
      target_w = dim_q[level_idx];
    end else begin
      target_w = peak_q[level_idx];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_q <= 2'h0;
    end else begin
      level_q <= level_d;
    end
  end

  // ****************************************************************
  // Fade engine
  // ****************************************************************
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_FADE = 1'b1
  } fade_state_type;

  fade_state_type state_q;
  fade_state_type state_d;
  logic [6:0] applied_d;
  logic [6:0] start_q;
  logic [6:0] start_d;
  logic [6:0] goal_q;
  logic [6:0] goal_d;
  logic [7:0] phase_q;
  logic [7:0] phase_d;
  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic [31:0] period_q;
  logic [31:0] period_d;
  logic [1:0] curve_q;
  logic [1:0] curve_d;
  logic [3:0] dur_code;
  logic [6:0] shaped;

  fade_shaper u_shaper (
    .i_start(start_q),
    .i_target(goal_q),
    .i_phase(phase_q),
    .i_curve(curve_q),
    .o_code(shaped)
  );

  always_comb begin
    state_d = state_q;
    applied_d = applied_q;
    start_d = start_q;
    goal_d = goal_q;
    phase_d = phase_q;
    tick_d = tick_q;
    period_d = period_q;
    curve_d = curve_q;
    // rising uses fade-in code, falling uses fade-out code
    dur_code = (target_w > applied_q) ? fade_in_code : fade_out_code;
    if (state_q == ST_FADE) begin
      applied_d = shaped;
    end
    // A new target, or one changed mid-fade, restarts from the code now applied
    if (target_w != ((state_q == ST_FADE) ? goal_q : applied_q)) begin
      if (dur_code == 4'h0) begin
        applied_d = target_w;
        goal_d = target_w;
        state_d = ST_IDLE;
      end else begin
        start_d = applied_q;
        goal_d = target_w;
        phase_d = 8'h00;
        tick_d = 32'h0;
        period_d = 32'(fade_units(dur_code)) * 32'(PHASE_CYC);
        // Curve is latched so a mid-fade change cannot make the code jump
        curve_d = i_fade_curve_sel;
        applied_d = applied_q;
        state_d = ST_FADE;
      end
    end else if (state_q == ST_FADE) begin
      if (phase_q == PHASE_LAST) begin
        state_d = ST_IDLE;
      end else if (tick_q + 32'h1 >= period_q) begin
        tick_d = 32'h0;
        phase_d = phase_q + 8'h01;
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      applied_q <= RST_CURRENT_CODE;
      start_q <= RST_CURRENT_CODE;
      goal_q <= RST_CURRENT_CODE;
      phase_q <= 8'h00;
      tick_q <= 32'h0;
      period_q <= 32'h0;
      curve_q <= 2'h0;
    end else begin
      state_q <= state_d;
      applied_q <= applied_d;
      start_q <= start_d;
      goal_q <= goal_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
      period_q <= period_d;
      curve_q <= curve_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_reg_rdata = rdata_q;
  assign o_sink_code = applied_q;
  assign o_active_level = level_q;
  assign o_fading = (state_q == ST_FADE);

endmodule : backlight_regs

`default_nettype wire

/* File: bench/backlight_regs_monitor.sv */
// Port checker for the backlight register bank
`default_nettype none
module backlight_regs_monitor
  import backlight_pkg::*;
#(
  parameter int PHASE_CYC = 1
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_reg_wr, // Write
  input wire logic [7:0] i_reg_addr, // Address
  input wire logic [7:0] i_reg_wdata, // Data in
  input wire logic [7:0] o_reg_rdata, // Data out
  input wire logic i_backlight_on, // Enable
  input wire logic i_dimmed, // Dimmed
  input wire logic [1:0] i_ambient_level_sel, // Host level
  input wire logic i_auto_level_enable, // Auto on
  input wire logic [1:0] i_auto_level, // Auto level
  input wire logic [1:0] i_fade_curve_sel, // Curve
  input wire logic [6:0] o_sink_code, // Sink code
  input wire logic [1:0] o_active_level, // Level
  input wire logic o_fading // Fading
);
  timeunit 1ns;
  timeprecision 1ns;
  // Shortest fade is code 1: 3 tenths times 128 phases, slack for latency
  localparam int MIN_FADE = 380 * PHASE_CYC;
  int len_q;
  int len_d;
  always_comb begin
    len_d = o_fading ? len_q + 1 : 0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      len_q <= 0;
    end else begin
      len_q <= len_d;
    end
  end
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  fade_reg_store_a: assert property (i_reg_wr && i_reg_addr == ADDR_FADE_DURATIONS ##1
    !i_reg_wr && i_reg_addr == ADDR_FADE_DURATIONS |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("fade register readback wrong");
  top_bit_zero_a: assert property (i_reg_addr >= ADDR_LEVEL1_PEAK && i_reg_addr <= ADDR_APPLIED_CODE
    |=> !o_reg_rdata[7]) else $error("bit 7 read as one");
  applied_view_a: assert property (i_reg_addr == ADDR_APPLIED_CODE
    |=> o_reg_rdata == {1'b0, $past(o_sink_code)}) else $error("applied code view wrong");
  host_level_a: assert property (!i_auto_level_enable && i_ambient_level_sel != 2'b11
    |=> o_active_level == $past(i_ambient_level_sel)) else $error("host level not in force");
  auto_level_a: assert property (i_auto_level_enable && i_auto_level != 2'b11
    |=> o_active_level == $past(i_auto_level)) else $error("auto level not in force");
  off_goes_dark_a: assert property (!i_backlight_on [*8] |-> o_fading || o_sink_code == 7'h00)
    else $error("sink not zero while off");
  fade_min_len_a: assert property ($fell(o_fading) |-> len_q >= MIN_FADE)
    else $error("fade too short");
  step_spacing_a: assert property (o_fading && $changed(o_sink_code) |=> $stable(o_sink_code))
    else $error("fade steps too close");
endmodule : backlight_regs_monitor
bind backlight_regs backlight_regs_monitor #(.PHASE_CYC(PHASE_CYC)) mon_u (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_backlight_on(i_backlight_on), .i_dimmed(i_dimmed),
  .i_ambient_level_sel(i_ambient_level_sel), .i_auto_level_enable(i_auto_level_enable),
  .i_auto_level(i_auto_level), .i_fade_curve_sel(i_fade_curve_sel), .o_sink_code(o_sink_code),
  .o_active_level(o_active_level), .o_fading(o_fading));
`default_nettype wire

/* File: bench/serial_host_model.sv */
// Host model: register writes, reads and backlight enable
`default_nettype none
module serial_host_model
  import backlight_pkg::*;
(
  input wire logic i_ref_clk, // Clock
  input wire logic [7:0] i_reg_rdata, // Read data
  output logic o_reg_wr = 1'b0, // Write strobe
  output logic [7:0] o_reg_addr = 8'h00, // Address
  output logic [7:0] o_reg_wdata = 8'h00, // Write data
  output logic o_backlight_on = 1'b0 // Enable
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_ref_clk);
    #1;
    o_reg_wr = 1'b0;
    // Stale data must not look valid
    o_reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_reg_addr = a;
    @(posedge i_ref_clk);
    #1;
    d = i_reg_rdata;
  endtask : rd
  task automatic light(input logic on, input logic [7:0] fade);
    if (on) begin
      wr(ADDR_FADE_DURATIONS, fade);
    end
    @(posedge i_ref_clk);
    #1;
    o_backlight_on = on;
  endtask : light
endmodule : serial_host_model
`default_nettype wire

/* File: bench/backlight_regs_tb_top.sv */
// Testbench for the backlight register bank
`default_nettype none
module backlight_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import backlight_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dimmed = 1'b0;
  logic [1:0] sel = 2'b00;
  logic auto_en = 1'b0;
  logic [1:0] auto_lvl = 2'b00;
  logic [1:0] curve = 2'b00;
  wire logic wr;
  wire logic bl_on;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic [6:0] sink;
  wire logic [1:0] act;
  wire logic fading;
  int mismatches = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  serial_host_model host_u (.i_ref_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_backlight_on(bl_on));
  backlight_regs #(.PHASE_CYC(1)) dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_backlight_on(bl_on),
    .i_dimmed(dimmed), .i_ambient_level_sel(sel), .i_auto_level_enable(auto_en),
    .i_auto_level(auto_lvl), .i_fade_curve_sel(curve), .o_sink_code(sink),
    .o_active_level(act), .o_fading(fading));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic t_regs();
    logic [7:0] d;
    for (int a = 4; a <= 11; a++) begin
      host_u.rd(8'(a), d);
      check("reset value", d, 8'h00);
    end
    for (int a = 5; a <= 11; a++) begin
      host_u.wr(8'(a), 8'h80 | 8'(a));
      host_u.rd(8'(a), d);
      check("current code", d, a == 11 ? 8'h00 : 8'(a));
    end
    host_u.wr(ADDR_FADE_DURATIONS, 8'hA5);
    host_u.rd(ADDR_FADE_DURATIONS, d);
    check("fade codes", d, 8'hA5);
  endtask : t_regs
  task automatic lvl(input logic [1:0] s, input logic dm, input logic [1:0] el, input logic [7:0] ec);
    logic [7:0] d;
    sel = s;
    dimmed = dm;
    repeat (4) @(posedge clk);
    #1;
    check("sink code", {1'b0, sink}, ec);
    check("level", {6'h00, act}, {6'h00, el});
    host_u.rd(ADDR_APPLIED_CODE, d);
    check("applied view", d, ec);
  endtask : lvl
  task automatic t_levels();
    host_u.light(1'b1, 8'h00);
    for (int l = 0; l < 3; l++) begin
      for (int d = 0; d < 2; d++) begin
        lvl(2'(l), 1'(d), 2'(l), 8'(5 + 2 * l + d));
      end
    end
    auto_en = 1'b1;
    auto_lvl = LEVEL_DARK;
    lvl(2'b00, 1'b0, 2'b10, 8'h09);
    auto_en = 1'b0;
    // spare code falls back to dark
    lvl(2'b11, 1'b0, 2'b11, 8'h09);
  endtask : t_levels
  task automatic fade_run(output int n, output logic [6:0] mid);
    int w;
    n = 0;
    w = 0;
    mid = 7'h00;
    while (fading !== 1'b1 && w < 10) begin
      @(posedge clk);
      #1;
      w++;
    end
    while (fading === 1'b1 && n < 6000) begin
      @(posedge clk);
      #1;
      n++;
      if (n == 192) begin
        mid = sink;
      end
    end
  endtask : fade_run
  task automatic t_fade();
    int n;
    logic [6:0] mid;
    logic [6:0] em [4] = '{7'h20, 7'h10, 7'h08, 7'h38};
    lvl(2'b00, 1'b0, 2'b00, 8'h05);
    host_u.light(1'b0, 8'h00);
    host_u.wr(ADDR_LEVEL1_PEAK, 8'h40);
    for (int c = 0; c < 4; c++) begin
      curve = 2'(c);
      host_u.light(1'b1, 8'hB1);
      fade_run(n, mid);
      check("fade in span", 8'(n > 380 && n < 392), 8'h01);
      check("mid code", 8'(mid > em[c] - 3 && mid < em[c] + 3), 8'h01);
      check("fade in end", {1'b0, sink}, 8'h40);
      host_u.light(1'b0, 8'h00);
      fade_run(n, mid);
      check("fade out span", 8'(n > 4476 && n < 4488), 8'h01);
      check("fade out end", {1'b0, sink}, 8'h00);
    end
  endtask : t_fade
  initial begin
    // Whole run is near 20000 cycles
    #(40000 * 50);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_levels();
    t_fade();
    end_sim();
  end
endmodule : backlight_regs_tb_top
`default_nettype wire
